// ==== logic/sasw_pkg.sv ====
package sasw_pkg;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W      = 4;
  localparam int CNT_W      = 5;
  // word 1 bit positions
  localparam int B_READY    = 0;
  localparam int B_ESTOP    = 1;
  localparam int B_INFO     = 2;
  localparam int B_MINOR    = 3;
  localparam int B_MAJOR    = 4;
  localparam int B_FULL     = 5;
  localparam int B_NEED_HOME = 8;
  localparam int B_HOMING   = 9;
  localparam int B_RETRACT  = 10;
  localparam int B_AT_HOME  = 11;
  localparam int B_OT_NEG   = 12;
  localparam int B_OT_POS   = 13;
  localparam int B_CFG_FAIL = 14;
  localparam int B_CFG_OK   = 15;
  // configuration word 1 view select bits
  localparam int SEL_LO     = 6;
  localparam int SEL_HI     = 7;
  // revision identifier, value arbitrary
  localparam logic [15:0] REV_ID = 16'h0A5C;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [1:0] {
    FK_INFO  = 2'h0,
    FK_MINOR = 2'h1,
    FK_MAJOR = 2'h2
  } sasw_kind_t;

  typedef enum logic [1:0] {
    CS_BOOT   = 2'h0,
    CS_OK     = 2'h1,
    CS_VERIFY = 2'h3,
    CS_FAIL   = 2'h2
  } sasw_cfg_t;

  typedef struct packed {
    logic homing;
    logic retract;
    logic at_home_tol;
    logic ot_neg;
    logic ot_pos;
    logic feedback_fault;
    logic homed_done;
  } sasw_axis_t;
endpackage

// ==== logic/sasw_status_words.sv ====
`timescale 1ns/1ps
module sasw_status_words (
  // clock and reset
  input  wire logic               clk_sys_in,
  input  wire logic               arst_n_in,
  // configuration and control
  input  wire logic [15:0]        cfg_word1_in,
  input  wire logic               powerup_ok_in,
  input  wire logic               report_inhibit_in,
  input  wire logic               estop_in,
  input  wire logic               estop_reset_in,
  // fault reporting
  input  wire logic               fault_push_in,
  input  wire sasw_pkg::sasw_kind_t fault_kind_in,
  input  wire logic               clear_one_in,
  input  wire logic               clear_all_in,
  // motion state
  input  wire sasw_pkg::sasw_axis_t axis_in,
  input  wire logic               blend_running_in,
  input  wire logic [15:0]        blend_segment_in,
  // bulk configuration transfer
  input  wire logic               bulk_config_transfer_in,
  input  wire logic               verify_done_in,
  input  wire logic               verify_pass_in,
  // status words
  output logic [15:0]             revision_or_segment_word_out,
  output logic [15:0]             axis_condition_word_out
);
  localparam int D = sasw_pkg::FIFO_DEPTH;

  // fault queue state
  logic [1:0]                 kind_q [D];
  logic [1:0]                 kind_d [D];
  logic [sasw_pkg::PTR_W-1:0] rd_q;
  logic [sasw_pkg::PTR_W-1:0] rd_d;
  logic [sasw_pkg::PTR_W-1:0] wr_q;
  logic [sasw_pkg::PTR_W-1:0] wr_d;
  logic [sasw_pkg::CNT_W-1:0] cnt_q;
  logic [sasw_pkg::CNT_W-1:0] cnt_d;
  logic                       push;
  logic                       pop;
  logic                       q_full;
  logic                       q_empty;
  logic                       has_info;
  logic                       has_minor;
  logic                       has_major;
  // sticky condition state
  logic                       ready_q;
  logic                       ready_d;
  logic                       estop_q;
  logic                       estop_d;
  logic                       need_home_q;
  logic                       need_home_d;
  // position condition state
  logic                       at_home_q;
  logic                       at_home_d;
  logic                       ot_neg_q;
  logic                       ot_neg_d;
  logic                       ot_pos_q;
  logic                       ot_pos_d;
  // configuration outcome state
  sasw_pkg::sasw_cfg_t        cfg_q;
  sasw_pkg::sasw_cfg_t        cfg_d;
  // status word registers
  logic [15:0]                w0_q;
  logic [15:0]                w0_d;
  logic [15:0]                w1_q;
  logic [15:0]                w1_d;

  function automatic logic [sasw_pkg::PTR_W-1:0] ptr_inc(
    input logic [sasw_pkg::PTR_W-1:0] p);
    return p + 1'b1;
  endfunction

  // full means every entry holds a report
  function automatic logic cnt_full(
    input logic [sasw_pkg::CNT_W-1:0] c);
    return (c == D[sasw_pkg::CNT_W-1:0]);
  endfunction

  function automatic logic [sasw_pkg::CNT_W-1:0] cnt_next(
    input logic [sasw_pkg::CNT_W-1:0] c,
    input logic                       inc,
    input logic                       dec);
    logic [sasw_pkg::CNT_W-1:0] n;
    n = c;
    // push and pop together leave the count alone
    if (inc && !dec) begin
      n = c + 1'b1;
    end else if (dec && !inc) begin
      n = c - 1'b1;
    end
    return n;
  endfunction

  function automatic logic [1:0] view_sel(input logic [15:0] cfg);
    return {cfg[sasw_pkg::SEL_HI], cfg[sasw_pkg::SEL_LO]};
  endfunction

  function automatic logic queued_kind(
    input logic [1:0]                 k [D],
    input logic [sasw_pkg::PTR_W-1:0] rd,
    input logic [sasw_pkg::CNT_W-1:0] cnt,
    input logic [1:0]                 want);
    logic                       f;
    logic [sasw_pkg::PTR_W-1:0] idx;
    f = 1'b0;
    for (int i = 0; i < D; i++) begin
      idx = rd + i[sasw_pkg::PTR_W-1:0];
      if ((i[sasw_pkg::CNT_W-1:0] < cnt) && (k[idx] == want)) begin
        f = 1'b1;
      end
    end
    return f;
  endfunction

  // fault queue
  always_comb begin
    q_full  = cnt_full(cnt_q);
    q_empty = (cnt_q == '0);
    // a full queue drops new reports, so the oldest ones stay for the host
    push    = fault_push_in && !report_inhibit_in && !q_full;
    pop     = clear_one_in && !q_empty;
    kind_d  = kind_q;
    rd_d    = rd_q;
    wr_d    = wr_q;
    cnt_d   = cnt_q;
    // clear-all beats a push or pop in the same cycle
    if (clear_all_in) begin
      rd_d  = '0;
      wr_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        kind_d[wr_q] = fault_kind_in;
        wr_d         = ptr_inc(wr_q);
      end
      if (pop) begin
        rd_d = ptr_inc(rd_q);
      end
      cnt_d = cnt_next(cnt_q, push, pop);
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < D; i++) begin
        kind_q[i] <= 2'h0;
      end
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else begin
      kind_q <= kind_d;
      rd_q   <= rd_d;
      wr_q   <= wr_d;
      cnt_q  <= cnt_d;
    end
  end

  // sticky power-up, estop and homing state
  always_comb begin
    ready_d     = ready_q | powerup_ok_in;
    estop_d     = estop_q;
    need_home_d = need_home_q;
    // an estop still present beats a reset request in the same cycle
    if (estop_in) begin
      estop_d = 1'b1;
    end else if (estop_reset_in) begin
      estop_d = 1'b0;
    end
    // a feedback fault beats a homing completion in the same cycle
    if (axis_in.feedback_fault) begin
      need_home_d = 1'b1;
    end else if (axis_in.homed_done) begin
      need_home_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_q     <= 1'b0;
      estop_q     <= 1'b0;
      need_home_q <= 1'b1;
    end else begin
      ready_q     <= ready_d;
      estop_q     <= estop_d;
      need_home_q <= need_home_d;
    end
  end

  // position conditions, registered from the motion inputs, with at-home forced low while homing
  always_comb begin
    at_home_d = axis_in.at_home_tol && !axis_in.homing;
    ot_neg_d  = axis_in.ot_neg;
    ot_pos_d  = axis_in.ot_pos;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      at_home_q <= 1'b0;
      ot_neg_q  <= 1'b0;
      ot_pos_q  <= 1'b0;
    end else begin
      at_home_q <= at_home_d;
      ot_neg_q  <= ot_neg_d;
      ot_pos_q  <= ot_pos_d;
    end
  end

  // configuration outcome; a transfer before power-up completes is ignored
  always_comb begin
    cfg_d = cfg_q;
    case (cfg_q)
      sasw_pkg::CS_BOOT: begin
        cfg_d = powerup_ok_in ? sasw_pkg::CS_OK : sasw_pkg::CS_BOOT;
      end
      sasw_pkg::CS_OK,
      sasw_pkg::CS_FAIL: begin
        cfg_d = bulk_config_transfer_in ? sasw_pkg::CS_VERIFY : cfg_q;
      end
      sasw_pkg::CS_VERIFY: begin
        if (verify_done_in) begin
          cfg_d = verify_pass_in ? sasw_pkg::CS_OK : sasw_pkg::CS_FAIL;
        end
      end
      default: begin
        cfg_d = sasw_pkg::CS_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q <= sasw_pkg::CS_BOOT;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign has_info  = queued_kind(kind_q, rd_q, cnt_q, sasw_pkg::FK_INFO);
  assign has_minor = queued_kind(kind_q, rd_q, cnt_q, sasw_pkg::FK_MINOR);
  assign has_major = queued_kind(kind_q, rd_q, cnt_q, sasw_pkg::FK_MAJOR);

  // status word composition
  always_comb begin
    w0_d = sasw_pkg::WORD_RST;
    case (view_sel(cfg_word1_in))
      2'b00:   w0_d = sasw_pkg::REV_ID;
      2'b01:   w0_d = blend_running_in ? blend_segment_in : sasw_pkg::WORD_RST;
      default: w0_d = sasw_pkg::WORD_RST;
    endcase

    w1_d = sasw_pkg::WORD_RST;
    w1_d[sasw_pkg::B_READY]     = ready_q;
    w1_d[sasw_pkg::B_ESTOP]     = estop_q;
    w1_d[sasw_pkg::B_INFO]      = has_info;
    w1_d[sasw_pkg::B_MINOR]     = has_minor;
    w1_d[sasw_pkg::B_MAJOR]     = has_major;
    w1_d[sasw_pkg::B_FULL]      = q_full;
    w1_d[sasw_pkg::B_NEED_HOME] = need_home_q;
    w1_d[sasw_pkg::B_HOMING]    = axis_in.homing;
    w1_d[sasw_pkg::B_RETRACT]   = axis_in.retract;
    w1_d[sasw_pkg::B_AT_HOME]   = at_home_q;
    w1_d[sasw_pkg::B_OT_NEG]    = ot_neg_q;
    w1_d[sasw_pkg::B_OT_POS]    = ot_pos_q;
    w1_d[sasw_pkg::B_CFG_FAIL]  = (cfg_q == sasw_pkg::CS_FAIL);
    w1_d[sasw_pkg::B_CFG_OK]    = (cfg_q == sasw_pkg::CS_OK);
  end

  // both words leave flip-flops, so the host never samples a word mid-update
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      w0_q <= sasw_pkg::WORD_RST;
      w1_q <= sasw_pkg::WORD_RST;
    end else begin
      w0_q <= w0_d;
      w1_q <= w1_d;
    end
  end

  assign revision_or_segment_word_out = w0_q;
  assign axis_condition_word_out      = w1_q;
endmodule

// ==== tb/sasw_host_model.sv ====
`timescale 1ns/1ps
// host image: costs a cycle, but no bit is trusted before ready shows
module sasw_host_model (
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  input  wire logic [15:0] word1_in,
  output logic      [15:0] view_out
);
  logic [15:0] view_d, view_q;
  always_comb view_d = word1_in[0] ? word1_in : 16'h0000;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) view_q <= 16'h0000;
    else view_q <= view_d;
  end
  assign view_out = view_q;
endmodule

// ==== tb/sasw_status_words_asserts.sv ====
`timescale 1ns/1ps
module sasw_status_words_asserts (
  input wire logic clk_sys_in, arst_n_in, powerup_ok_in, report_inhibit_in, estop_in,
  input wire logic estop_reset_in, fault_push_in, clear_one_in, clear_all_in,
  input wire logic blend_running_in, bulk_config_transfer_in, verify_done_in, verify_pass_in,
  input wire logic [15:0] cfg_word1_in, blend_segment_in,
  input wire sasw_pkg::sasw_kind_t fault_kind_in,
  input wire sasw_pkg::sasw_axis_t axis_in,
  input wire logic [15:0] revision_or_segment_word_out, axis_condition_word_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // age counter keeps $past away from values sampled during reset
  logic [1:0] age_q;
  wire        up = age_q == 2'h3;
  wire [15:0] w0 = revision_or_segment_word_out;
  wire [15:0] w1 = axis_condition_word_out;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) age_q <= 2'h0;
    else if (!up) age_q <= age_q + 2'h1;
  end
  a_rev_view: assert property (up && cfg_word1_in[7:6] == 2'h0 |=> w0 == sasw_pkg::REV_ID)
    else $error("word 0 not revision");
  a_seg_view: assert property (up && cfg_word1_in[7:6] == 2'h1 && blend_running_in
    |=> w0 == $past(blend_segment_in)) else $error("word 0 not segment");
  a_seg_idle: assert property (up && cfg_word1_in[7:6] == 2'h1 && !blend_running_in
    |=> w0 == 16'h0000) else $error("idle segment not zero");
  a_hi_sel: assert property (up && cfg_word1_in[7] |=> w0 == 16'h0000)
    else $error("undefined view not zero");
  a_resv_zero: assert property (w1[7:6] == 2'h0) else $error("reserved bits set");
  a_homing_bit: assert property (up |-> w1[9] == $past(axis_in.homing))
    else $error("homing bit wrong");
  a_retract_bit: assert property (up |-> w1[10] == $past(axis_in.retract))
    else $error("retract bit wrong");
  a_estop_set: assert property (up && estop_in |-> ##[1:2] w1[1]) else $error("estop not set");
  a_estop_hold: assert property (up && $fell(w1[1])
    |-> $past(estop_reset_in) || $past(estop_reset_in, 2)) else $error("estop cleared alone");
  a_major_set: assert property (up && fault_push_in && fault_kind_in == sasw_pkg::FK_MAJOR
    && !report_inhibit_in && !w1[5] && !$past(fault_push_in) && !clear_all_in |-> ##[1:3] w1[4])
    else $error("major fault not shown");
  a_home_quiet: assert property (up && axis_in.homing && $past(axis_in.homing)
    |=> !w1[11]) else $error("at home during homing");
  c_seg: cover property (cfg_word1_in[7:6] == 2'h1 && blend_running_in);
  c_full: cover property (w1[5]);
  c_estop_clr: cover property ($fell(w1[1]));
  c_cfg_fail: cover property (w1[14]);
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  typedef struct {logic [15:0] cfg; logic run; logic [15:0] seg; logic [15:0] exp;} sasw_row_t;
  logic clk_sys_in = 0, arst_n_in = 0, powerup_ok_in = 0, report_inhibit_in = 0;
  logic estop_in = 0, estop_reset_in = 0, fault_push_in = 0, clear_one_in = 0;
  logic clear_all_in = 0, blend_running_in = 0, bulk_config_transfer_in = 0;
  logic verify_done_in = 0, verify_pass_in = 0;
  logic [15:0] cfg_word1_in = 16'h0000, blend_segment_in = 16'h0000, w0, w1, hv;
  sasw_pkg::sasw_kind_t fault_kind_in = sasw_pkg::FK_INFO;
  sasw_pkg::sasw_axis_t axis_in = '0;
  int err_count = 0, n_compared = 0;
  sasw_row_t rows [7] = '{'{16'h0000, 1, 16'h0005, sasw_pkg::REV_ID},
    '{16'hFF3F, 0, 16'h0000, sasw_pkg::REV_ID}, '{16'h0040, 1, 16'h0005, 16'h0005},
    '{16'h0040, 1, 16'hFFFF, 16'hFFFF}, '{16'h0040, 0, 16'h0007, 16'h0000},
    '{16'h0080, 1, 16'h0005, 16'h0000}, '{16'h00C0, 1, 16'h0005, 16'h0000}};
  always #5 clk_sys_in = ~clk_sys_in;
  sasw_status_words dut (.clk_sys_in, .arst_n_in, .cfg_word1_in, .powerup_ok_in,
    .report_inhibit_in, .estop_in, .estop_reset_in, .fault_push_in, .fault_kind_in,
    .clear_one_in, .clear_all_in, .axis_in, .blend_running_in, .blend_segment_in,
    .bulk_config_transfer_in, .verify_done_in, .verify_pass_in,
    .revision_or_segment_word_out(w0), .axis_condition_word_out(w1));
  sasw_host_model host (.clk_sys_in, .arst_n_in, .word1_in(w1), .view_out(hv));
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
    tick(1);
  endtask
  task automatic push(sasw_pkg::sasw_kind_t k);
    fault_kind_in = k;
    pulse(fault_push_in);
  endtask
  task conclude;
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard: a stuck run counts as a mismatch
  initial begin
    #200000;
    err_count++;
    conclude;
  end
  initial begin
    tick(3);
    arst_n_in = 1;
    tick(3);
    chk(hv, 16'h0000);
    powerup_ok_in = 1;
    tick(4);
    chk(w1, 16'h8101);
    foreach (rows[i]) begin
      cfg_word1_in = rows[i].cfg;
      blend_running_in = rows[i].run;
      blend_segment_in = rows[i].seg;
      tick(2);
      chk(w0, rows[i].exp);
    end
    push(sasw_pkg::FK_INFO);
    push(sasw_pkg::FK_MINOR);
    push(sasw_pkg::FK_MAJOR);
    tick(4);
    chk(hv[4:2], 3'h7);
    pulse(clear_one_in);
    tick(4);
    chk(hv[4:2], 3'h6);
    report_inhibit_in = 1;
    push(sasw_pkg::FK_INFO);
    report_inhibit_in = 0;
    tick(4);
    chk(hv[4:2], 3'h6);
    pulse(clear_all_in);
    tick(4);
    chk(hv[5:2], 4'h0);
    repeat (15) push(sasw_pkg::FK_MINOR);
    tick(4);
    chk(hv[5], 1'b0);
    push(sasw_pkg::FK_MINOR);
    tick(4);
    chk(hv[5:3], 3'h5);
    push(sasw_pkg::FK_MAJOR);
    tick(4);
    chk(hv[5:3], 3'h5);
    pulse(clear_one_in);
    tick(4);
    chk(hv[5], 1'b0);
    pulse(clear_all_in);
    pulse(estop_in);
    tick(4);
    chk(hv[1], 1'b1);
    pulse(estop_reset_in);
    tick(4);
    chk(hv[1], 1'b0);
    axis_in = '{homing: 1, at_home_tol: 1, default: 0};
    tick(4);
    chk(hv[11:9], 3'h1);
    axis_in.homing = 0;
    tick(4);
    chk(hv[11:9], 3'h4);
    axis_in = '{retract: 1, ot_neg: 1, ot_pos: 1, homed_done: 1, default: 0};
    tick(4);
    chk(hv[13:8], 6'h34);
    axis_in = '{feedback_fault: 1, default: 0};
    tick(4);
    chk(hv[13:8], 6'h01);
    pulse(bulk_config_transfer_in);
    tick(3);
    chk(hv[15:14], 2'h0);
    pulse(verify_done_in);
    tick(4);
    chk(hv[15:14], 2'h1);
    pulse(bulk_config_transfer_in);
    verify_pass_in = 1;
    pulse(verify_done_in);
    tick(4);
    chk(hv[15:14], 2'h2);
    arst_n_in = 0;
    tick(1);
    chk(w1, 16'h0000);
    conclude;
  end
endmodule
bind sasw_status_words sasw_status_words_asserts chk_i (.clk_sys_in, .arst_n_in,
  .powerup_ok_in, .report_inhibit_in, .estop_in, .estop_reset_in, .fault_push_in,
  .clear_one_in, .clear_all_in, .blend_running_in, .bulk_config_transfer_in,
  .verify_done_in, .verify_pass_in, .cfg_word1_in, .blend_segment_in, .fault_kind_in,
  .axis_in, .revision_or_segment_word_out, .axis_condition_word_out);
